// ===== sddr_pkg.sv
// Shared constants, types and helpers of the separate-I/O DDR memory pin interface.
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package sddr_pkg;

  // -------------------------------------------------------------------------
  // Widths and field positions
  // -------------------------------------------------------------------------
  localparam int ADDR_W       = 21;
  localparam int BANK_W       = 3;
  localparam int DATA_W       = 18;
  localparam int HALF_W       = 9;
  localparam int COL_W        = 3;
  localparam int MEM_AW       = BANK_W + COL_W;
  localparam int FIFO_AW      = 3;
  localparam int PAIR_CNT_W   = 3;
  localparam int MODE_BL_LSB  = 3;
  localparam int MODE_ZQ_BIT  = 8;

  // Reset values and burst length codes of the mode register.
  localparam logic [ADDR_W-1:0]     MODE_RESET = 21'h000000;
  localparam logic [1:0]            BL_CODE_2  = 2'h0;
  localparam logic [1:0]            BL_CODE_4  = 2'h1;
  localparam logic [PAIR_CNT_W-1:0] PAIRS_BL2  = 3'h1;
  localparam logic [PAIR_CNT_W-1:0] PAIRS_BL4  = 3'h2;
  localparam logic [PAIR_CNT_W-1:0] PAIRS_BL8  = 3'h4;

  // Timing: main clock period and synchroniser depth.
  localparam int MCLK_PERIOD_PS = 4000;
  localparam int SYNC_STAGES    = 2;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SDDR_CMD_NOP   = 3'h0,
    SDDR_CMD_READ  = 3'h1,
    SDDR_CMD_WRITE = 3'h2,
    SDDR_CMD_REFR  = 3'h3,
    SDDR_CMD_MODE  = 3'h4
  } sddr_cmd_t;

  typedef enum logic [1:0] {
    SDDR_RD_IDLE  = 2'h0,
    SDDR_RD_FETCH = 2'h1,
    SDDR_RD_LOW   = 2'h2,
    SDDR_RD_HIGH  = 2'h3
  } sddr_rd_state_t;

  // One write clock period: the rising beat and the falling beat with masks.
  typedef struct packed {
    logic              mask_hi;
    logic [DATA_W-1:0] data_hi;
    logic              mask_lo;
    logic [DATA_W-1:0] data_lo;
  } sddr_pair_t;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // Pair count of a burst from the mode register field.
  function automatic logic [PAIR_CNT_W-1:0] sddr_pairs(input logic [ADDR_W-1:0] mode);
    logic [1:0] code;
    code = mode[MODE_BL_LSB +: 2];
    if (code == BL_CODE_2) begin
      return PAIRS_BL2;
    end else if (code == BL_CODE_4) begin
      return PAIRS_BL4;
    end else begin
      return PAIRS_BL8;
    end
  endfunction

  // Memory word index of a burst pair; the column wraps inside the bank.
  function automatic logic [MEM_AW-1:0] sddr_index(input logic [BANK_W-1:0] bank,
                                                   input logic [COL_W-1:0]  col,
                                                   input logic [PAIR_CNT_W-1:0] off);
    return {bank, col + off};
  endfunction

  // Binary to gray conversion of a FIFO pointer.
  function automatic logic [FIFO_AW:0] sddr_gray(input logic [FIFO_AW:0] bin);
    return bin ^ (bin >> 1);
  endfunction

endpackage

// ===== sddr_buf2.sv
// Two-entry valid/ready buffer for write data pairs.
`timescale 1ns/10ps
`default_nettype none
module sddr_buf2
  import sddr_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // Filling side
  input  wire logic       in_valid_in,
  input  var  sddr_pair_t in_pair_in,
  output logic            in_ready_out,
  // Draining side
  output logic            out_valid_out,
  output sddr_pair_t      out_pair_out,
  input  wire logic       out_ready_in
);

  sddr_pair_t  slot [2];
  logic        rd_sel;
  logic        wr_sel;
  logic [1:0]  count;
  logic        push;
  logic        pop;

  assign push          = in_valid_in && (count != 2'h2);
  assign pop           = out_valid_out && out_ready_in;
  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_pair_out  = slot[rd_sel];

  // Occupancy; full and empty follow it exactly so the source really stalls.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      count <= 2'h0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Ring pointers and storage.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_sel <= 1'b0;
      wr_sel <= 1'b0;
    end else begin
      if (push) begin
        wr_sel <= ~wr_sel;
      end
      if (pop) begin
        rd_sel <= ~rd_sel;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (push) begin
      slot[wr_sel] <= in_pair_in;
    end
  end

endmodule
`default_nettype wire

// ===== sddr_mem.sv
// Small array of burst pairs with per-beat write enables and registered read.
`timescale 1ns/10ps
`default_nettype none
module sddr_mem
  import sddr_pkg::*;
(
  // Clock
  input  wire logic              mclk_in,
  // Write port
  input  wire logic              wr_lo_in,
  input  wire logic              wr_hi_in,
  input  wire logic [MEM_AW-1:0] wr_index_in,
  input  var  sddr_pair_t        wr_pair_in,
  // Read port
  input  wire logic              rd_in,
  input  wire logic [MEM_AW-1:0] rd_index_in,
  output sddr_pair_t             rd_pair_out
);

  logic [DATA_W-1:0] lo_mem [2**MEM_AW];
  logic [DATA_W-1:0] hi_mem [2**MEM_AW];

  // Each half has its own enable so a masked beat leaves the old word.
  always_ff @(posedge mclk_in) begin
    if (wr_lo_in) begin
      lo_mem[wr_index_in] <= wr_pair_in.data_lo;
    end
    if (wr_hi_in) begin
      hi_mem[wr_index_in] <= wr_pair_in.data_hi;
    end
  end

  // Read data come out of a register one cycle after the request.
  always_ff @(posedge mclk_in) begin
    if (rd_in) begin
      rd_pair_out <= '{mask_hi: 1'b0, data_hi: hi_mem[rd_index_in],
                       mask_lo: 1'b0, data_lo: lo_mem[rd_index_in]};
    end
  end

endmodule
`default_nettype wire

// ===== sddr_top.sv
// Pin interface of the separate-I/O DDR memory: command capture, write and read paths.
`timescale 1ns/10ps
`default_nettype none
module sddr_top
  import sddr_pkg::*;
(
  // Clocks and reset
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  input  wire logic              write_data_clock_in,
  // Command pins, synchronous to the main clock
  input  wire logic              chip_select_n_in,
  input  wire logic              write_cmd_n_in,
  input  wire logic              refresh_cmd_n_in,
  input  wire logic [ADDR_W-1:0] row_column_address_inputs_in,
  input  wire logic [BANK_W-1:0] bank_select_inputs_in,
  // Write data pins, synchronous to the write data clock
  input  wire logic [DATA_W-1:0] write_data_bus_in,
  input  wire logic              write_mask_in,
  // Organisation strap
  input  wire logic              org_x18_in,
  // Read data pins
  output logic [DATA_W-1:0]      read_data_bus_out,
  output logic                   read_valid_flag_out,
  output logic                   first_output_clock_pair_out,
  output logic                   first_output_clock_pair_n_out,
  output logic                   second_output_clock_pair_out,
  output logic                   second_output_clock_pair_n_out,
  // Status
  output logic                   impedance_tuning_out,
  output logic [ADDR_W-1:0]      mode_value_out,
  output logic                   busy_out
);

  // -------------------------------------------------------------------------
  // Main clock domain declarations
  // -------------------------------------------------------------------------
  sddr_cmd_t              cmd;
  logic [ADDR_W-1:0]      mode_reg;
  logic [1:0]             org_sync;
  sddr_rd_state_t         rd_state;
  logic [BANK_W-1:0]      rd_bank;
  logic [COL_W-1:0]       rd_col;
  logic [PAIR_CNT_W-1:0]  rd_off;
  logic [PAIR_CNT_W-1:0]  rd_pairs;
  logic                   mem_rd;
  sddr_pair_t             mem_q;
  logic                   wr_busy;
  logic [BANK_W-1:0]      wr_bank;
  logic [COL_W-1:0]       wr_col;
  logic [PAIR_CNT_W-1:0]  wr_off;
  logic [PAIR_CNT_W-1:0]  wr_pairs;
  logic                   wr_toggle;
  logic [FIFO_AW:0]       rptr;
  logic [FIFO_AW:0]       rptr_gray;
  logic [FIFO_AW:0]       wgray_s1;
  logic [FIFO_AW:0]       wgray_s2;
  logic                   fifo_empty;
  logic                   buf_in_ready;
  logic                   buf_valid;
  sddr_pair_t             buf_pair;
  logic                   buf_take;
  logic                   qk_phase;

  // -------------------------------------------------------------------------
  // Write clock domain declarations
  // -------------------------------------------------------------------------
  logic [1:0]             dk_rst_sync;
  logic                   dk_rst;
  logic [2:0]             dk_tog_sync;
  logic [PAIR_CNT_W-1:0]  dk_left;
  logic                   dk_take;
  logic                   rise_mask;
  logic [DATA_W-1:0]      rise_data;
  logic                   fall_mask;
  logic [DATA_W-1:0]      fall_data;
  sddr_pair_t             fifo_mem [2**FIFO_AW];
  logic [FIFO_AW:0]       wptr;
  logic [FIFO_AW:0]       wptr_gray;
  logic [FIFO_AW:0]       rgray_s1;
  logic [FIFO_AW:0]       rgray_s2;
  logic                   fifo_full;

  // -------------------------------------------------------------------------
  // Command decode
  // -------------------------------------------------------------------------
  // Pins are sampled on the main clock; a high select blocks every new command
  // while the read and write engines below keep running.
  always_comb begin
    if (chip_select_n_in) begin
      cmd = SDDR_CMD_NOP;
    end else if (!write_cmd_n_in && !refresh_cmd_n_in) begin
      cmd = SDDR_CMD_MODE;
    end else if (!write_cmd_n_in) begin
      cmd = SDDR_CMD_WRITE;
    end else if (!refresh_cmd_n_in) begin
      cmd = SDDR_CMD_REFR;
    end else begin
      cmd = SDDR_CMD_READ;
    end
  end

  // Mode register: the address pins become the settings, not a location.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mode_reg <= MODE_RESET;
    end else if (cmd == SDDR_CMD_MODE) begin
      mode_reg <= row_column_address_inputs_in;
    end
  end

  // The strap is a pin from outside the clock domain, so it is synchronised.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      org_sync <= 2'h0;
    end else begin
      org_sync <= {org_sync[0], org_x18_in};
    end
  end

  // -------------------------------------------------------------------------
  // Read engine
  // -------------------------------------------------------------------------
  // A read burst fetches one pair, then shows its rising and falling beats on
  // two consecutive cycles; the next fetch overlaps the falling beat.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_state <= SDDR_RD_IDLE;
      rd_bank  <= '0;
      rd_col   <= '0;
      rd_off   <= '0;
      rd_pairs <= '0;
    end else begin
      case (rd_state)
        SDDR_RD_IDLE: begin
          if (cmd == SDDR_CMD_READ) begin
            rd_bank  <= bank_select_inputs_in;
            rd_col   <= row_column_address_inputs_in[COL_W-1:0];
            rd_off   <= '0;
            rd_pairs <= sddr_pairs(mode_reg);
            rd_state <= SDDR_RD_FETCH;
          end
        end
        SDDR_RD_FETCH: begin
          rd_state <= SDDR_RD_LOW;
        end
        SDDR_RD_LOW: begin
          rd_state <= SDDR_RD_HIGH;
        end
        SDDR_RD_HIGH: begin
          if (rd_off + 3'h1 == rd_pairs) begin
            rd_state <= SDDR_RD_IDLE;
          end else begin
            rd_off   <= rd_off + 3'h1;
            rd_state <= SDDR_RD_LOW;
          end
        end
        default: begin
          rd_state <= SDDR_RD_IDLE;
        end
      endcase
    end
  end

  // Memory read request: entering a burst, and during each falling beat that
  // has another pair behind it.
  assign mem_rd = (rd_state == SDDR_RD_FETCH) ||
                  ((rd_state == SDDR_RD_HIGH) && (rd_off + 3'h1 != rd_pairs));

  // Output beats change on the same edge the output clocks toggle, so both
  // clock edges frame one beat each and the valid flag moves with them.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      read_data_bus_out   <= '0;
      read_valid_flag_out <= 1'b0;
    end else begin
      read_valid_flag_out <= (rd_state == SDDR_RD_LOW) || (rd_state == SDDR_RD_HIGH);
      if (rd_state == SDDR_RD_LOW) begin
        read_data_bus_out <= mem_q.data_lo;
      end else if (rd_state == SDDR_RD_HIGH) begin
        read_data_bus_out <= mem_q.data_hi;
      end else begin
        read_data_bus_out <= '0;
      end
      if (!org_sync[1]) begin
        read_data_bus_out[DATA_W-1:HALF_W] <= '0;
      end
    end
  end

  // Output clocks run free at half the main clock; pair two only runs in the
  // wide organisation, where it frames the upper nine bits.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      qk_phase                       <= 1'b0;
      first_output_clock_pair_out    <= 1'b0;
      first_output_clock_pair_n_out  <= 1'b1;
      second_output_clock_pair_out   <= 1'b0;
      second_output_clock_pair_n_out <= 1'b1;
    end else begin
      qk_phase                       <= ~qk_phase;
      first_output_clock_pair_out    <= ~qk_phase;
      first_output_clock_pair_n_out  <= qk_phase;
      second_output_clock_pair_out   <= org_sync[1] & ~qk_phase;
      second_output_clock_pair_n_out <= ~(org_sync[1] & ~qk_phase);
    end
  end

  // -------------------------------------------------------------------------
  // Write engine, main clock side
  // -------------------------------------------------------------------------
  // A write command records where its burst goes and flips a toggle that
  // arms the write clock side; a second write during a burst is ignored and lost.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_busy   <= 1'b0;
      wr_bank   <= '0;
      wr_col    <= '0;
      wr_off    <= '0;
      wr_pairs  <= '0;
      wr_toggle <= 1'b0;
    end else begin
      if (!wr_busy && (cmd == SDDR_CMD_WRITE)) begin
        wr_busy   <= 1'b1;
        wr_bank   <= bank_select_inputs_in;
        wr_col    <= row_column_address_inputs_in[COL_W-1:0];
        wr_off    <= '0;
        wr_pairs  <= sddr_pairs(mode_reg);
        wr_toggle <= ~wr_toggle;
      end else if (buf_take) begin
        wr_off <= wr_off + 3'h1;
        if (wr_off + 3'h1 == wr_pairs) begin
          wr_busy <= 1'b0;
        end
      end
    end
  end

  // Reads take priority at the memory; writes stall in the buffer meanwhile.
  assign buf_take = buf_valid && !mem_rd && wr_busy;

  sddr_mem u_mem (
    .mclk_in     (mclk_in),
    .wr_lo_in    (buf_take && !buf_pair.mask_lo),
    .wr_hi_in    (buf_take && !buf_pair.mask_hi),
    .wr_index_in (sddr_index(wr_bank, wr_col, wr_off)),
    .wr_pair_in  (buf_pair),
    .rd_in       (mem_rd),
    .rd_index_in (sddr_index(rd_bank, rd_col, rd_off + {2'h0, (rd_state == SDDR_RD_HIGH)})),
    .rd_pair_out (mem_q)
  );

  sddr_buf2 u_buf (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .in_valid_in   (!fifo_empty),
    .in_pair_in    (fifo_mem[rptr[FIFO_AW-1:0]]),
    .in_ready_out  (buf_in_ready),
    .out_valid_out (buf_valid),
    .out_pair_out  (buf_pair),
    .out_ready_in  (buf_take)
  );

  // Crossing FIFO read side: gray pointers pass through two flip-flops.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rptr      <= '0;
      rptr_gray <= '0;
      wgray_s1  <= '0;
      wgray_s2  <= '0;
    end else begin
      wgray_s1 <= wptr_gray;
      wgray_s2 <= wgray_s1;
      if (!fifo_empty && buf_in_ready) begin
        rptr      <= rptr + 4'h1;
        rptr_gray <= sddr_gray(rptr + 4'h1);
      end
    end
  end

  assign fifo_empty = (rptr_gray == wgray_s2);

  // Status outputs.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      impedance_tuning_out <= 1'b0;
      mode_value_out       <= MODE_RESET;
      busy_out             <= 1'b0;
    end else begin
      impedance_tuning_out <= mode_reg[MODE_ZQ_BIT];
      mode_value_out       <= mode_reg;
      busy_out             <= wr_busy || (rd_state != SDDR_RD_IDLE);
    end
  end

  // -------------------------------------------------------------------------
  // Write clock domain
  // -------------------------------------------------------------------------
  // Reset is carried over as a level; the write clock must run while it does.
  always_ff @(posedge write_data_clock_in) begin
    dk_rst_sync <= {dk_rst_sync[0], reset_in};
  end

  assign dk_rst = dk_rst_sync[1];

  // Every data and mask bit is sampled on both edges of the one write clock.
  always_ff @(posedge write_data_clock_in) begin
    rise_mask <= write_mask_in;
    rise_data <= write_data_bus_in;
  end

  always_ff @(negedge write_data_clock_in) begin
    fall_mask <= write_mask_in;
    fall_data <= write_data_bus_in;
  end

  // The arming toggle is synchronised; its burst length is held still by the
  // main side until the burst ends, so it is safe to read on the edge.
  always_ff @(posedge write_data_clock_in) begin
    if (dk_rst) begin
      dk_tog_sync <= '0;
      dk_left     <= '0;
      dk_take     <= 1'b0;
    end else begin
      dk_tog_sync <= {dk_tog_sync[1:0], wr_toggle};
      if (dk_tog_sync[2] != dk_tog_sync[1]) begin
        dk_left <= wr_pairs;
        dk_take <= 1'b0;
      end else if (dk_left != '0) begin
        dk_left <= dk_left - 3'h1;
        dk_take <= 1'b1;
      end else begin
        dk_take <= 1'b0;
      end
    end
  end

  // Push one pair per write clock period; a full FIFO drops the pair.
  always_ff @(posedge write_data_clock_in) begin
    if (dk_rst) begin
      wptr      <= '0;
      wptr_gray <= '0;
      rgray_s1  <= '0;
      rgray_s2  <= '0;
    end else begin
      rgray_s1 <= rptr_gray;
      rgray_s2 <= rgray_s1;
      if (dk_take && !fifo_full) begin
        wptr      <= wptr + 4'h1;
        wptr_gray <= sddr_gray(wptr + 4'h1);
      end
    end
  end

  always_ff @(posedge write_data_clock_in) begin
    if (dk_take && !fifo_full) begin
      fifo_mem[wptr[FIFO_AW-1:0]] <= '{mask_hi: fall_mask, data_hi: fall_data,
                                       mask_lo: rise_mask, data_lo: rise_data};
    end
  end

  assign fifo_full = (wptr_gray == {~rgray_s2[FIFO_AW:FIFO_AW-1], rgray_s2[FIFO_AW-2:0]});

endmodule
`default_nettype wire

// ===== sddr_checker.sv
// Pin-level assertions of the DDR memory pin interface.
`timescale 1ns/10ps
`default_nettype none
module sddr_checker
  import sddr_pkg::*;
(
  // Clock, reset and command pins
  input wire logic              mclk_in,
  input wire logic              reset_in,
  input wire logic              chip_select_n_in,
  input wire logic              write_cmd_n_in,
  input wire logic              refresh_cmd_n_in,
  input wire logic [ADDR_W-1:0] row_column_address_inputs_in,
  input wire logic              org_x18_in,
  // Read side and status
  input wire logic [DATA_W-1:0] read_data_bus_out,
  input wire logic              read_valid_flag_out,
  input wire logic              first_output_clock_pair_out,
  input wire logic              first_output_clock_pair_n_out,
  input wire logic              second_output_clock_pair_out,
  input wire logic              second_output_clock_pair_n_out,
  input wire logic              impedance_tuning_out,
  input wire logic [ADDR_W-1:0] mode_value_out,
  input wire logic              busy_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic [3:0] run;
  logic [3:0] beats;
  logic       rd_cmd;
  // Beats per burst are worked out here, not borrowed from the design.
  assign beats  = (mode_value_out[4:3] == 2'h0) ? 4'h2 : (mode_value_out[4:3] == 2'h1) ? 4'h4 : 4'h8;
  assign rd_cmd = !chip_select_n_in && write_cmd_n_in && refresh_cmd_n_in;
  // Length of the current valid run, so a short or long burst is caught.
  always_ff @(posedge mclk_in) begin
    run <= (reset_in || !read_valid_flag_out) ? 4'h0 : run + 4'h1;
  end
  a_qk_toggle: assert property ($past(!reset_in, 2) |-> first_output_clock_pair_out != $past(first_output_clock_pair_out))
    else $error("output clock stopped");
  a_qk_compl: assert property (first_output_clock_pair_n_out != first_output_clock_pair_out)
    else $error("output clock pair not complementary");
  a_wide_pair: assert property (org_x18_in [*5] |-> second_output_clock_pair_out == first_output_clock_pair_out)
    else $error("second clock pair not aligned");
  a_narrow_park: assert property (!org_x18_in [*5] |-> !second_output_clock_pair_out && second_output_clock_pair_n_out
    && read_data_bus_out[17:9] == 9'h000)
    else $error("narrow organisation drives upper half");
  a_burst_len: assert property ($fell(read_valid_flag_out) |-> run == beats)
    else $error("read burst has wrong beat count");
  a_read_lat: assert property (rd_cmd && !busy_out && !read_valid_flag_out |-> ##2 !read_valid_flag_out ##1 read_valid_flag_out)
    else $error("read valid late or early");
  a_mode_load: assert property (!chip_select_n_in && !write_cmd_n_in && !refresh_cmd_n_in
    |-> ##3 mode_value_out == $past(row_column_address_inputs_in, 3))
    else $error("mode not loaded from address");
  a_imp_bit: assert property ($stable(mode_value_out) |-> impedance_tuning_out == mode_value_out[MODE_ZQ_BIT])
    else $error("impedance tuning does not follow mode");
  a_cs_mode: assert property (chip_select_n_in [*5] |-> $stable(mode_value_out))
    else $error("mode changed while deselected");
  a_cs_read: assert property (chip_select_n_in [*5] |-> !$rose(read_valid_flag_out))
    else $error("read started while deselected");
  c_bl8: cover property ($rose(read_valid_flag_out) && beats == 4'h8);
  c_narrow: cover property ($rose(read_valid_flag_out) && !org_x18_in);
  c_write: cover property ($fell(busy_out) && !read_valid_flag_out);
endmodule
`default_nettype wire

// ===== sddr_host.sv
// Host model that launches write bursts on the write data clock.
`timescale 1ns/10ps
`default_nettype none
module sddr_host
  import sddr_pkg::*;
(
  // Clocks and burst request
  input  wire logic              mclk_in,
  input  wire logic              dk_in,
  input  wire logic              go_in,
  input  wire logic [3:0]        beats_in,
  input  wire logic [DATA_W-1:0] base_in,
  input  wire logic [7:0]        mask_in,
  // Write pins
  output logic      [DATA_W-1:0] data_out,
  output logic                   mask_out
);
  initial begin
    data_out = 18'h00000;
    mask_out = 1'b0;
  end
  // Each beat changes just after the previous write clock edge, so the first
  // beat stands at the fourth write clock rise after the command.
  always @(posedge mclk_in) begin
    if (go_in) begin
      repeat (3) @(posedge dk_in);
      for (int k = 0; k < beats_in; k++) begin
        @(dk_in);
        #1 data_out = base_in + k[DATA_W-1:0];
        mask_out = mask_in[k];
      end
      @(dk_in);
      // Idle data is inverted so that a late capture shows up; mask rests low.
      #1 data_out = ~data_out;
      mask_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sddr_tb_top.sv
// Testbench of the DDR pin interface against a behavioural memory model.
`timescale 1ns/10ps
`default_nettype none
module sddr_tb_top;
  import sddr_pkg::*;
  logic              mclk_in, reset_in, dk, cs_n, we_n, ref_n, org, go, wmask, rvalid;
  logic              qk0, qk0_n, qk1, qk1_n, imp, busy;
  logic [ADDR_W-1:0] addr, mode, v;
  logic [BANK_W-1:0] bank, b;
  logic [DATA_W-1:0] wdata, rdata, base;
  logic [2:0]        col;
  logic [7:0]        msk;
  logic [3:0]        bl;
  logic [DATA_W-1:0] mem [int];
  int                bad_count, total_checks;
  sddr_top i_sddr_top (.mclk_in(mclk_in), .reset_in(reset_in), .write_data_clock_in(dk),
    .chip_select_n_in(cs_n), .write_cmd_n_in(we_n), .refresh_cmd_n_in(ref_n),
    .row_column_address_inputs_in(addr), .bank_select_inputs_in(bank), .write_data_bus_in(wdata),
    .write_mask_in(wmask), .org_x18_in(org), .read_data_bus_out(rdata), .read_valid_flag_out(rvalid),
    .first_output_clock_pair_out(qk0), .first_output_clock_pair_n_out(qk0_n),
    .second_output_clock_pair_out(qk1), .second_output_clock_pair_n_out(qk1_n),
    .impedance_tuning_out(imp), .mode_value_out(mode), .busy_out(busy));
  sddr_host i_sddr_host (.mclk_in(mclk_in), .dk_in(dk), .go_in(go), .beats_in(bl), .base_in(base),
    .mask_in(msk), .data_out(wdata), .mask_out(wmask));
  // Write clock is free running so the write clock side is reset along with the design.
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  initial begin
    dk = 1'b0;
    #3.3;
    forever #7.5 dk = ~dk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One command cycle; deselected cycles carry random write, refresh and address pin values.
  task automatic cmd(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [2:0] bk);
    cs_n = 1'b0;
    {we_n, ref_n, addr, bank} = {w, r, a, bk};
    @(negedge mclk_in);
    cs_n = 1'b1;
    {we_n, ref_n, addr} = $urandom;
  endtask
  function automatic int key(input logic [2:0] bk, input logic [2:0] c, input int k);
    return {bk, 3'(c + k / 2), k[0]};
  endfunction
  task automatic setm(input logic [1:0] code);
    v = $urandom;
    v[4:3] = code;
    bl = (code == 2'h0) ? 4'h2 : (code == 2'h1) ? 4'h4 : 4'h8;
    cmd(1'b0, 1'b0, v, 3'($urandom));
    repeat (2) @(negedge mclk_in);
    chk(mode, v);
    chk(imp, v[MODE_ZQ_BIT]);
  endtask
  task automatic wr(input logic [2:0] bk, input logic [7:0] m);
    int w;
    base = $urandom;
    msk = m;
    go = 1'b1;
    cmd(1'b0, 1'b1, 21'(col), bk);
    go = 1'b0;
    for (int k = 0; k < bl; k++) begin
      if (!m[k]) mem[key(bk, col, k)] = base + k[DATA_W-1:0];
    end
    repeat (4) @(negedge mclk_in);
    for (w = 0; busy !== 1'b0 && w < 200; w++) @(negedge mclk_in);
    chk(w < 200, 1);
  endtask
  task automatic rd(input logic [2:0] bk);
    int w;
    cmd(1'b1, 1'b1, 21'(col), bk);
    for (w = 0; rvalid !== 1'b1 && w < 10; w++) @(negedge mclk_in);
    chk(w, 2);
    for (int k = 0; k < bl; k++) begin
      chk(rdata, mem[key(bk, col, k)] & (org ? 18'h3FFFF : 18'h001FF));
      @(negedge mclk_in);
    end
    chk(rvalid, 0);
  endtask
  initial begin
    #100000;
    bad_count++;
    results();
  end
  // Each pass sets a burst length, writes, overwrites with masks and reads back.
  initial begin
    void'($urandom(78));
    {reset_in, cs_n, we_n, ref_n, addr, bank, go, org, bl, base, msk} = {4'hF, 24'h0, 1'b0, 1'b1, 30'h0};
    repeat (16) @(negedge mclk_in);
    reset_in = 1'b0;
    for (int o = 1; o >= 0; o--) begin
      org = o[0];
      repeat (4) @(negedge mclk_in);
      chk({qk1, qk1_n}, o ? {qk0, qk0_n} : 2'h1);
      for (int c = 0; c < 4; c++) begin
        b = $urandom;
        col = $urandom;
        setm(c[1:0]);
        wr(b, 8'h00);
        wr(b ^ 3'h1, 8'h00);
        wr(b, 8'($urandom));
        rd(b);
        $display("test org %0d code %0d done", o, c);
      end
    end
    setm(2'h3);
    cmd(1'b1, 1'b0, ~v, 3'h0);
    repeat (8) @(negedge mclk_in);
    chk(mode, v);
    chk(rvalid, 0);
    $display("test deselect and refresh done");
    results();
  end
endmodule
bind sddr_top sddr_checker i_sddr_checker (.*);
`default_nettype wire
